// *** bench/mps_far_model.sv ***
// Behavioural model of the data path, decode and flag logic beside the sequencer.
`timescale 1ns/1ps
module mps_far_model (
  // Clock
  input  wire logic                      clk_i,
  // Requests from the bench
  input  wire logic                      force_req_i,
  input  wire logic [mps_pkg::UPF_W-1:0] force_adr_i,
  input  wire logic [mps_pkg::UW_W-1:0]  expand_req_i,
  input  wire logic [1:0]                ir_req_i,
  // Branch sources
  output logic      [mps_pkg::CODE_W-1:0] grp_one_o,
  output logic      [mps_pkg::CODE_W-1:0] grp_two_o,
  output logic      [mps_pkg::CODE_W-1:0] grp_three_o,
  output logic      [1:0]                 ir_o,
  output logic      [mps_pkg::FLAG_N-1:0] flag_o,
  // Expansion and forced address
  output logic      [mps_pkg::UW_W-1:0]   expand_o,
  output logic                            force_o,
  output logic      [mps_pkg::UPF_W-1:0]  force_adr_o
);
  // ****************************************************************
  // Decode codes differ per group so a swapped select shows up.
  // ****************************************************************
  assign grp_one_o   = 5'h15;
  assign grp_two_o   = 5'h0a;
  assign grp_three_o = 5'h1f;
  assign flag_o      = 6'h08;

  // ****************************************************************
  // IR, expansion and forced address flops; they change only after a clock edge.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    ir_o        <= ir_req_i;
    expand_o    <= expand_req_i;
    force_o     <= force_req_i;
    force_adr_o <= force_adr_i;
  end
endmodule : mps_far_model

// *** bench/tb.sv ***
// Self-checking bench for the microprogram sequencer.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, ss, cp, fld, frq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdo, rdat;
  logic [4:0]  g1, g2, g3;
  logic [1:0]  ir, irq;
  logic [5:0]  flg;
  logic [56:0] exb, exq;
  logic [8:0]  fad, fadq, ptr, past;
  logic [56:9] uwc;
  int          err_total, total_checks, nk, pl;
  int          n_pulse = 0;
  logic [56:0] mw;
  logic [8:0]  adrs [8] = '{9'h000, 9'h010, 9'h020, 9'h055, 9'h061, 9'h081, 9'h0aa, 9'h0df};
  logic [8:0]  nxt [8] = '{9'h010, 9'h020, 9'h040, 9'h060, 9'h080, 9'h0a0, 9'h0c0, 9'h100};
  logic [3:0]  bsl [8] = '{4'h0, 4'h1, 4'h4, 4'hb, 4'h2, 4'h3, 4'h5, 4'h0};
  logic [1:0]  lens [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
  logic        ce [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  mps_seq u_mps_seq (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .instr_branch_group_one_i(g1), .instr_branch_group_two_i(g2),
    .instr_branch_group_three_i(g3), .ir_branch_i(ir), .flag_branch_i(flg),
    .expand_bus_i(exb), .forced_address_load_i(fld), .forced_addr_i(fad),
    .uw_control_o(uwc), .next_microaddress_pointer_o(ptr),
    .past_microaddress_register_o(past), .state_start_o(ss), .clk_pulse_o(cp));
  mps_far_model u_mps_far_model (
    .clk_i(clk_i), .force_req_i(frq), .force_adr_i(fadq), .expand_req_i(exq),
    .ir_req_i(irq), .grp_one_o(g1), .grp_two_o(g2), .grp_three_o(g3), .ir_o(ir),
    .flag_o(flg), .expand_o(exb), .force_o(fld), .force_adr_o(fad));

  // ****************************************************************
  // Clock, watchdog and verdict
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    end_of_test();
  end

  // ****************************************************************
  // Wishbone classic cycle; no answer latency is assumed.
  // ****************************************************************
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    `CHK("ack idle", 1'b0, ack)
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  function automatic logic [56:0] mk(int i);
    return {41'h1_2345_6789_ab ^ (41'(i) << 20), ce[i], lens[i], bsl[i], ~nxt[i]};
  endfunction : mk
  // Pulses are counted on every edge, since a one-cycle state ends on the ack edge.
  always @(posedge clk_i) begin
    if (cp === 1'b1) n_pulse <= n_pulse + 1;
  end
  task automatic step(output int n, output int p);
    int c0;
    c0 = n_pulse;
    wb(1'b1, mps_pkg::A_CTRL, 32'h0000_0002);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ss !== 1'b1);
    p = n_pulse - c0;
  endtask : step

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    err_total = 0;
    total_checks = 0;
    rst_i = 1'b1;
    {cyc, stb, we, frq} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    fadq = 9'h000;
    exq = 57'h0;
    irq = 2'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("ptr rst", 9'h000, ptr)
    `CHK("uw rst", 48'h0, uwc)
    `CHK("past rst", 9'h000, past)
    $display("reset test done");
    // Store loaded word by word; low half first, high half commits.
    for (int i = 0; i < 8; i++) begin
      mw = mk(i);
      wb(1'b1, mps_pkg::A_LDADR, {24'h0, adrs[i][7:0]});
      wb(1'b1, mps_pkg::A_LDLO, mw[31:0]);
      wb(1'b1, mps_pkg::A_LDHI, {7'h0, mw[56:32]});
    end
    // The expansion bit is ORed only into the first loaded word.
    // The branch chosen by word k-2 alters the address held in word k-1.
    exq <= 57'h1 << 50;
    for (int k = 1; k <= 8; k++) begin
      irq <= (k == 8) ? 2'b10 : 2'b01;
      step(nk, pl);
      exq <= 57'h0;
      mw = mk(k-1);
      `CHK("ptr", (k < 8) ? adrs[k] : 9'h101, ptr)
      `CHK("past", adrs[k-1], past)
      `CHK("uw", mw[56:9] | ((k == 1) ? 48'h1 << 41 : 48'h0), uwc)
      `CHK("len", 1 + ((k > 1) ? int'(lens[k-2]) : 0), nk)
      `CHK("pulse", (k > 1) ? int'(ce[k-2]) : 0, pl)
    end
    $display("branch chain test done");
    repeat (10) @(posedge clk_i);
    `CHK("ptr hold", 9'h101, ptr)
    wb(1'b0, mps_pkg::A_PTR, 32'h0);
    `CHK("ptr reg", 32'h101, rdat)
    wb(1'b0, mps_pkg::A_PAST, 32'h0);
    `CHK("past reg", 32'h0df, rdat)
    wb(1'b0, mps_pkg::A_CURLO, 32'h0);
    mw = mk(7);
    `CHK("cur lo", {mw[31:9], 9'h000}, rdat)
    wb(1'b0, mps_pkg::A_CURHI, 32'h0);
    `CHK("cur hi", {7'h0, mw[56:32]}, rdat)
    wb(1'b0, mps_pkg::A_LDHI, 32'h0);
    `CHK("ldhi rd", 32'h0, rdat)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    $display("register test done");
    @(posedge clk_i);
    frq <= 1'b1;
    fadq <= 9'h1ab;
    @(posedge clk_i);
    frq <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("forced", 9'h1ab, ptr)
    wb(1'b1, mps_pkg::A_JAM, 32'h033);
    wb(1'b1, mps_pkg::A_CTRL, 32'h0000_0004);
    wb(1'b0, mps_pkg::A_PTR, 32'h0);
    `CHK("jam", 32'h033, rdat)
    $display("forced address test done");
    end_of_test();
  end
endmodule : tb

// *** logic/mps_altmux.sv ***
// One graded alteration multiplexer; out-of-range selects give zero.
`timescale 1ns/1ps
module mps_altmux #(
  parameter int N  = 4,
  parameter int SW = 2
) (
  // Inputs
  input  wire logic [N-1:0]  d_i,
  input  wire logic [SW-1:0] s_i,
  input  wire logic          en_i,
  // Output
  output logic               q_o
);
  always_comb begin
    q_o = 1'b0;
    if (en_i && (int'(s_i) < N)) begin
      q_o = d_i[s_i];
    end
  end
endmodule : mps_altmux

// *** logic/mps_cstore.sv ***
// Control store array with one write port and an asynchronous read.
`timescale 1ns/1ps
module mps_cstore #(
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int W     = 57
) (
  // Clock
  input  wire logic          clk_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] wa_i,
  input  wire logic [W-1:0]  wd_i,
  // Read port
  input  wire logic [AW-1:0] ra_i,
  output logic      [W-1:0]  rd_o
);
  logic [W-1:0] mem [DEPTH];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Contents are undefined until software loads them.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  assign rd_o = mem[ra_i];
endmodule : mps_cstore

// *** logic/mps_pkg.sv ***
// Constants shared by the microprogram sequencer files.
package mps_pkg;

  // ****************************************************************
  // Microword layout
  // ****************************************************************
  localparam int UW_W      = 57;
  localparam int UPF_W     = 9;
  localparam int CS_DEPTH  = 256;
  localparam int CS_AW     = 8;
  localparam int ALT_W     = 6;
  localparam int CODE_W    = 5;
  localparam int FLAG_N    = 6;
  localparam int BSEL_LSB  = 9;
  localparam int BSEL_W    = 4;
  localparam int CLEN_LSB  = 13;
  localparam int CLEN_W    = 2;
  localparam int CLKEN_BIT = 15;
  localparam logic [UPF_W-1:0] RESET_ADDR = 9'h000;

  // ****************************************************************
  // Branch select codes
  // ****************************************************************
  localparam logic [BSEL_W-1:0] BSEL_NONE = 4'h0;
  localparam logic [BSEL_W-1:0] BSEL_G1   = 4'h1;
  localparam logic [BSEL_W-1:0] BSEL_G2   = 4'h2;
  localparam logic [BSEL_W-1:0] BSEL_G3   = 4'h3;
  localparam logic [BSEL_W-1:0] BSEL_IR0  = 4'h4;
  localparam logic [BSEL_W-1:0] BSEL_IR1  = 4'h5;
  localparam logic [BSEL_W-1:0] BSEL_FLAG = 4'h8;

  // ****************************************************************
  // Register offsets and control bits
  // ****************************************************************
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_JAM     = 8'h04;
  localparam logic [7:0] A_PTR     = 8'h08;
  localparam logic [7:0] A_PAST    = 8'h0c;
  localparam logic [7:0] A_LDADR   = 8'h10;
  localparam logic [7:0] A_LDLO    = 8'h14;
  localparam logic [7:0] A_LDHI    = 8'h18;
  localparam logic [7:0] A_CURLO   = 8'h1c;
  localparam logic [7:0] A_CURHI   = 8'h20;
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_STEP = 1;
  localparam int CTRL_JAM  = 2;

endpackage : mps_pkg

// *** logic/mps_seq.sv ***
// Microprogram control store and next-address sequencer with Wishbone access.
`timescale 1ns/1ps
module mps_seq (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  // Branch sources
  input  wire logic [mps_pkg::CODE_W-1:0]    instr_branch_group_one_i,
  input  wire logic [mps_pkg::CODE_W-1:0]    instr_branch_group_two_i,
  input  wire logic [mps_pkg::CODE_W-1:0]    instr_branch_group_three_i,
  input  wire logic [1:0]                    ir_branch_i,
  input  wire logic [mps_pkg::FLAG_N-1:0]    flag_branch_i,
  // Expansion and forced address
  input  wire logic [mps_pkg::UW_W-1:0]      expand_bus_i,
  input  wire logic                          forced_address_load_i,
  input  wire logic [mps_pkg::UPF_W-1:0]     forced_addr_i,
  // Machine control outputs
  output logic      [mps_pkg::UW_W-1:mps_pkg::UPF_W] uw_control_o,
  output logic      [mps_pkg::UPF_W-1:0]     next_microaddress_pointer_o,
  output logic      [mps_pkg::UPF_W-1:0]     past_microaddress_register_o,
  output logic                               state_start_o,
  output logic                               clk_pulse_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [mps_pkg::UW_W-1:mps_pkg::UPF_W] uw_r;
  logic [mps_pkg::UPF_W-1:0]   ptr_r;
  logic [mps_pkg::UPF_W-1:0]   past_r;
  logic [mps_pkg::CLEN_W-1:0]  cnt_r;
  logic                        start_r;
  logic                        run_r;
  logic                        step_r;
  logic                        jam_r;
  logic [mps_pkg::UPF_W-1:0]   jam_addr_r;
  logic [mps_pkg::CS_AW-1:0]   ld_addr_r;
  logic [31:0]                 ld_lo_r;
  logic                        cs_we_r;
  logic [mps_pkg::UW_W-1:0]    cs_wd_r;
  logic [mps_pkg::UW_W-1:0]    cs_q;
  logic [mps_pkg::UW_W-1:0]    ubus;
  logic                        ack_r;
  logic [31:0]                 dat_r;
  logic [31:0]                 rd_nxt;
  logic                        wr;
  logic [31:0]                 wmask;
  logic [mps_pkg::BSEL_W-1:0]  bsel;
  logic [mps_pkg::CLEN_W-1:0]  clen;
  logic [mps_pkg::ALT_W-1:0]   alt;
  logic [mps_pkg::UPF_W-1:0]   ptr_nxt;
  logic [mps_pkg::UPF_W-1:0]   force_addr;
  logic                        force_ld;
  logic                        state_end;
  logic                        bit0_a;
  logic                        bit0_b;

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // Every access, mapped or not, is acknowledged one cycle after it starts.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      mps_pkg::A_CTRL:  rd_nxt[mps_pkg::CTRL_RUN] = run_r;
      mps_pkg::A_JAM:   rd_nxt[mps_pkg::UPF_W-1:0] = jam_addr_r;
      mps_pkg::A_PTR:   rd_nxt[mps_pkg::UPF_W-1:0] = ptr_r;
      mps_pkg::A_PAST:  rd_nxt[mps_pkg::UPF_W-1:0] = past_r;
      mps_pkg::A_LDADR: rd_nxt[mps_pkg::CS_AW-1:0] = ld_addr_r;
      mps_pkg::A_LDLO:  rd_nxt = ld_lo_r;
      mps_pkg::A_CURLO: rd_nxt[31:mps_pkg::UPF_W] = uw_r[31:mps_pkg::UPF_W];
      mps_pkg::A_CURHI: rd_nxt[mps_pkg::UW_W-33:0] = uw_r[mps_pkg::UW_W-1:32];
      default:          rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
      dat_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Step and jam are one-shot: step holds until one state ends.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r  <= 1'b0;
      step_r <= 1'b0;
      jam_r  <= 1'b0;
    end else begin
      jam_r <= 1'b0;
      if (state_end) begin
        step_r <= 1'b0;
      end
      if (wr && wb_adr_i == mps_pkg::A_CTRL && wb_sel_i[0]) begin
        run_r <= wb_dat_i[mps_pkg::CTRL_RUN];
        jam_r <= wb_dat_i[mps_pkg::CTRL_JAM];
        if (wb_dat_i[mps_pkg::CTRL_STEP]) begin
          step_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jam_addr_r <= mps_pkg::RESET_ADDR;
    end else if (wr && wb_adr_i == mps_pkg::A_JAM) begin
      jam_addr_r <= (jam_addr_r & ~wmask[mps_pkg::UPF_W-1:0])
                  | (wb_dat_i[mps_pkg::UPF_W-1:0] & wmask[mps_pkg::UPF_W-1:0]);
    end
  end

  // ****************************************************************
  // Control store loading
  // ****************************************************************
  // A high-word write commits the word and advances the load address.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_addr_r <= '0;
      ld_lo_r   <= 32'h0000_0000;
      cs_we_r   <= 1'b0;
      cs_wd_r   <= '0;
    end else begin
      cs_we_r <= 1'b0;
      if (wr && wb_adr_i == mps_pkg::A_LDADR) begin
        ld_addr_r <= wb_dat_i[mps_pkg::CS_AW-1:0];
      end
      if (wr && wb_adr_i == mps_pkg::A_LDLO) begin
        ld_lo_r <= (ld_lo_r & ~wmask) | (wb_dat_i & wmask);
      end
      if (cs_we_r) begin
        ld_addr_r <= ld_addr_r + 1'b1;
      end
      if (wr && wb_adr_i == mps_pkg::A_LDHI) begin
        cs_we_r <= 1'b1;
        cs_wd_r <= {wb_dat_i[mps_pkg::UW_W-33:0], ld_lo_r};
      end
    end
  end

  mps_cstore #(
    .DEPTH (mps_pkg::CS_DEPTH),
    .AW    (mps_pkg::CS_AW),
    .W     (mps_pkg::UW_W)
  ) u_cstore (
    .clk_i (clk_i),
    .we_i  (cs_we_r),
    .wa_i  (ld_addr_r),
    .wd_i  (cs_wd_r),
    .ra_i  (ptr_r[mps_pkg::CS_AW-1:0]),
    .rd_o  (cs_q)
  );

  // Expansion units add bits onto the same output bus.
  assign ubus = cs_q | expand_bus_i;

  // ****************************************************************
  // Branch test multiplexer
  // ****************************************************************
  assign bsel = uw_r[mps_pkg::BSEL_LSB +: mps_pkg::BSEL_W];
  assign clen = uw_r[mps_pkg::CLEN_LSB +: mps_pkg::CLEN_W];

  // Bit 0 carries the narrow branches; flags never reach higher bits.
  mps_altmux #(.N(6), .SW(3)) u_b0a (
    .d_i  ({ir_branch_i, instr_branch_group_three_i[0],
            instr_branch_group_two_i[0], instr_branch_group_one_i[0], 1'b0}),
    .s_i  (bsel[2:0]),
    .en_i (!bsel[3]),
    .q_o  (bit0_a)
  );

  mps_altmux #(.N(6), .SW(3)) u_b0b (
    .d_i  (flag_branch_i),
    .s_i  (bsel[2:0]),
    .en_i (bsel[3]),
    .q_o  (bit0_b)
  );

  assign alt[0] = bit0_a | bit0_b;

  mps_altmux #(.N(16), .SW(4)) u_b1 (
    .d_i  ({12'h000, instr_branch_group_three_i[1],
            instr_branch_group_two_i[1], instr_branch_group_one_i[1], 1'b0}),
    .s_i  (bsel),
    .en_i (1'b1),
    .q_o  (alt[1])
  );

  for (genvar b = 2; b < 4; b++) begin : g_mid
    mps_altmux #(.N(8), .SW(3)) u_m (
      .d_i  ({4'h0, instr_branch_group_three_i[b],
              instr_branch_group_two_i[b], instr_branch_group_one_i[b], 1'b0}),
      .s_i  (bsel[2:0]),
      .en_i (!bsel[3]),
      .q_o  (alt[b])
    );
  end

  // Codes are five bits wide, so the top alteration bit has no source.
  for (genvar b = 4; b < mps_pkg::ALT_W; b++) begin : g_high
    logic [2:0] src;
    if (b < mps_pkg::CODE_W) begin : g_src
      assign src = {instr_branch_group_three_i[b], instr_branch_group_two_i[b],
                    instr_branch_group_one_i[b]};
    end else begin : g_zero
      assign src = 3'h0;
    end
    mps_altmux #(.N(4), .SW(2)) u_h (
      .d_i  ({src, 1'b0}),
      .s_i  (bsel[1:0]),
      .en_i (bsel[3:2] == 2'h0),
      .q_o  (alt[b])
    );
  end

  // ****************************************************************
  // Machine state timing
  // ****************************************************************
  // A state lasts clen+1 cycles; the count only moves while running or stepping.
  assign state_end = (run_r || step_r) && (cnt_r == clen);
  assign clk_pulse_o = state_end && uw_r[mps_pkg::CLKEN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (state_end) begin
      cnt_r <= '0;
    end else if (run_r || step_r) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
    end else begin
      start_r <= state_end;
    end
  end

  assign state_start_o = start_r;

  // ****************************************************************
  // Microword register and pointer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uw_r <= '0;
    end else if (state_end) begin
      uw_r <= ubus[mps_pkg::UW_W-1:mps_pkg::UPF_W];
    end
  end

  // The inverting gate restores the complemented field and ORs in the
  // alteration chosen by the word now executing, so it lands two words on.
  assign ptr_nxt = ~ubus[mps_pkg::UPF_W-1:0]
                 | {{(mps_pkg::UPF_W-mps_pkg::ALT_W){1'b0}}, alt};
  assign force_ld = forced_address_load_i || jam_r;
  assign force_addr = forced_address_load_i ? forced_addr_i : jam_addr_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= mps_pkg::RESET_ADDR;
    end else if (force_ld) begin
      ptr_r <= force_addr;
    end else if (state_end) begin
      ptr_r <= ptr_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      past_r <= mps_pkg::RESET_ADDR;
    end else if (state_end) begin
      past_r <= ptr_r;
    end
  end

  assign uw_control_o = uw_r;
  assign next_microaddress_pointer_o = ptr_r;
  assign past_microaddress_register_o = past_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_uw_load;
    @(posedge clk_i) disable iff (rst_i)
      state_end |=> uw_r == $past(ubus[mps_pkg::UW_W-1:mps_pkg::UPF_W]);
  endproperty
  a_uw_load: assert property (p_uw_load) else $error("microword not loaded");

  property p_ptr_next;
    @(posedge clk_i) disable iff (rst_i)
      state_end && !force_ld |=>
        ptr_r == ($past(~ubus[mps_pkg::UPF_W-1:0]) | {3'h0, $past(alt)});
  endproperty
  a_ptr_next: assert property (p_ptr_next) else $error("pointer not altered");

  property p_past;
    @(posedge clk_i) disable iff (rst_i)
      state_end |=> past_r == $past(ptr_r);
  endproperty
  a_past: assert property (p_past) else $error("past address wrong");

  property p_force;
    @(posedge clk_i) disable iff (rst_i)
      force_ld |=> ptr_r == $past(force_addr);
  endproperty
  a_force: assert property (p_force) else $error("forced address lost");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      !state_end && !force_ld |=> $stable(ptr_r) && $stable(uw_r);
  endproperty
  a_hold: assert property (p_hold) else $error("state changed mid state");

  property p_flag_bit;
    @(posedge clk_i) disable iff (rst_i)
      bsel[3] |-> alt[mps_pkg::ALT_W-1:1] == '0;
  endproperty
  a_flag_bit: assert property (p_flag_bit) else $error("flag altered high bit");

  property p_none;
    @(posedge clk_i) disable iff (rst_i)
      bsel == mps_pkg::BSEL_NONE |-> alt == '0;
  endproperty
  a_none: assert property (p_none) else $error("alteration without select");

  property p_pulse;
    @(posedge clk_i) disable iff (rst_i)
      clk_pulse_o |-> state_end ##1 state_start_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("clock pulse misplaced");

  property p_len;
    @(posedge clk_i) disable iff (rst_i)
      cnt_r <= clen;
  endproperty
  a_len: assert property (p_len) else $error("state longer than length");

endmodule : mps_seq
